// file: sppt_map.vh
// Register offsets, field positions and reset values of the slave port
`ifndef SPPT_MAP_VH
`define SPPT_MAP_VH
`define SPPT_ADDR_W 4
`define SPPT_OFS_DATA_PORT 4'h0
`define SPPT_OFS_DATA_LATCH 4'h1
`define SPPT_OFS_DATA_DIR 4'h2
`define SPPT_OFS_CTL_PORT 4'h3
`define SPPT_OFS_CTL_LATCH 4'h4
`define SPPT_OFS_CTL_STATUS 4'h5
`define SPPT_OFS_IRQ_FLAGS 4'h6
`define SPPT_OFS_IRQ_ENABLE 4'h7
`define SPPT_OFS_IRQ_PRIO 4'h8
`define SPPT_OFS_ANALOG_CFG 4'h9
`define SPPT_BIT_IN_PEND 7
`define SPPT_BIT_OUT_PEND 6
`define SPPT_BIT_OVERRUN 5
`define SPPT_BIT_SEL 4
`define SPPT_BIT_SPIRQ 7
`define SPPT_RST_DATA_DIR 8'hFF
`define SPPT_RST_CTL_DIR 3'h7
`define SPPT_RST_ZERO8 8'h00
`define SPPT_RST_ZERO3 3'h0
`define SPPT_PCFG_DIGITAL 3'h7
`endif

// file: sppt_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module sppt_sync
#(
	parameter W = 3,
	parameter [W-1:0] INIT = {W{1'b1}}
)
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [W-1:0] i_async,
	output reg [W-1:0] o_sync
);
	reg [W-1:0] meta_reg;
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			meta_reg <= INIT;
			o_sync <= INIT;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule

// file: sppt_top.v
// Parallel slave port with control pins and an Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`include "sppt_map.vh"
module sppt_top
#(
	parameter DW = 8
)
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [`SPPT_ADDR_W-1:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] i_writedata,
	output reg [31:0] o_readdata,
	output reg o_waitrequest,
	input wire [DW-1:0] i_data_pin,
	output reg [DW-1:0] o_data_pin,
	output reg [DW-1:0] o_data_oe,
	input wire [2:0] i_ctl_pin,
	output reg [2:0] o_ctl_pin,
	output reg [2:0] o_ctl_oe,
	output reg o_irq
);
	// Data pins: input word, output latch, direction
	reg [DW-1:0] in_word_reg;
	reg [DW-1:0] data_latch_reg;
	reg [DW-1:0] data_dir_reg;
	reg [2:0] ctl_latch_reg;
	reg [2:0] ctl_dir_reg;
	reg sel_reg;
	reg in_pend_reg;
	reg out_pend_reg;
	reg overrun_reg;
	reg [7:0] irq_flag_reg;
	reg [7:0] irq_en_reg;
	reg [7:0] irq_prio_reg;
	reg [7:0] analog_cfg_reg;
	reg ack_reg;
	reg wr_pair_reg;
	reg rd_pair_reg;
	wire [2:0] ctl_sync;
	wire [DW-1:0] data_sync;
	wire acc;
	wire wr_acc;
	wire rd_acc;
	wire [2:0] ctl_digital;
	wire [2:0] ctl_rd_val;
	wire rd_low;
	wire wr_low;
	wire cs_low;
	wire wr_pair;
	wire rd_pair;
	wire ext_wr;
	wire ext_rd;
	wire ext_rd_end;
	wire core_rd_data;
	wire core_wr_data;
	wire wr_status;
	wire wr_flags;
	reg [7:0] rdata_next;

	sppt_sync #(.W(3), .INIT(3'h7)) u_ctl_sync
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_ctl_pin),
		.o_sync(ctl_sync)
	);

	sppt_sync #(.W(DW), .INIT({DW{1'b0}})) u_data_sync
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_data_pin),
		.o_sync(data_sync)
	);

	// Single-wait-state bus slave: answer on the cycle after the request
	assign acc = (i_read | i_write) & !ack_reg;
	assign wr_acc = i_write & ack_reg;
	assign rd_acc = i_read & ack_reg;

	// All three control pins read zero unless all three are configured digital
	assign ctl_digital = (analog_cfg_reg[2:0] == `SPPT_PCFG_DIGITAL) ?
		3'h7 : 3'h0;
	assign ctl_rd_val = ctl_sync & ctl_digital;
	assign rd_low = !ctl_rd_val[0] & sel_reg;
	assign wr_low = !ctl_rd_val[1] & sel_reg;
	assign cs_low = !ctl_rd_val[2] & sel_reg;
	assign wr_pair = cs_low & wr_low;
	assign rd_pair = cs_low & rd_low;
	assign ext_wr = wr_pair & !wr_pair_reg;
	assign ext_rd = rd_pair & !rd_pair_reg;
	assign ext_rd_end = !rd_pair & rd_pair_reg;
	assign core_rd_data = rd_acc && (i_address == `SPPT_OFS_DATA_PORT);
	assign core_wr_data = wr_acc && ((i_address == `SPPT_OFS_DATA_PORT) ||
		(i_address == `SPPT_OFS_DATA_LATCH));
	assign wr_status = wr_acc && (i_address == `SPPT_OFS_CTL_STATUS);
	assign wr_flags = wr_acc && (i_address == `SPPT_OFS_IRQ_FLAGS);

	always @*
	begin
		rdata_next = 8'h00;
		case (i_address)
			`SPPT_OFS_DATA_PORT:
				rdata_next = sel_reg ? in_word_reg : data_sync;
			`SPPT_OFS_DATA_LATCH:
				rdata_next = data_latch_reg;
			`SPPT_OFS_DATA_DIR:
				rdata_next = data_dir_reg;
			`SPPT_OFS_CTL_PORT:
				rdata_next = {5'h00, ctl_rd_val};
			`SPPT_OFS_CTL_LATCH:
				rdata_next = {5'h00, ctl_latch_reg};
			`SPPT_OFS_CTL_STATUS:
				rdata_next = {in_pend_reg, out_pend_reg, overrun_reg,
					sel_reg, 1'b0, ctl_dir_reg};
			`SPPT_OFS_IRQ_FLAGS:
				rdata_next = irq_flag_reg;
			`SPPT_OFS_IRQ_ENABLE:
				rdata_next = irq_en_reg;
			`SPPT_OFS_IRQ_PRIO:
				rdata_next = irq_prio_reg;
			`SPPT_OFS_ANALOG_CFG:
				rdata_next = analog_cfg_reg;
			default:
				rdata_next = 8'h00;
		endcase
	end

	// Bus handshake: one wait state, answer and read data registered
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			ack_reg <= 1'b0;
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= acc;
			o_waitrequest <= !acc;
			if (acc & i_read)
				o_readdata <= {24'h000000, rdata_next};
		end
	end

	// Previous strobe pairing, for first-detection edges
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			wr_pair_reg <= 1'b0;
			rd_pair_reg <= 1'b0;
		end
		else
		begin
			wr_pair_reg <= wr_pair;
			rd_pair_reg <= rd_pair;
		end
	end

	// Pin direction, pin latch and mode select
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			data_dir_reg <= `SPPT_RST_DATA_DIR;
			ctl_latch_reg <= `SPPT_RST_ZERO3;
			ctl_dir_reg <= `SPPT_RST_CTL_DIR;
			sel_reg <= 1'b0;
		end
		else if (wr_acc)
		begin
			case (i_address)
				`SPPT_OFS_DATA_DIR:
					data_dir_reg <= i_writedata[DW-1:0];
				`SPPT_OFS_CTL_PORT:
					ctl_latch_reg <= i_writedata[2:0];
				`SPPT_OFS_CTL_LATCH:
					ctl_latch_reg <= i_writedata[2:0];
				`SPPT_OFS_CTL_STATUS:
				begin
					sel_reg <= i_writedata[`SPPT_BIT_SEL];
					ctl_dir_reg <= i_writedata[2:0];
				end
				default:
					ctl_dir_reg <= ctl_dir_reg;
			endcase
		end
	end

	// Interrupt enables, priorities and analog pin configuration
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			irq_en_reg <= `SPPT_RST_ZERO8;
			irq_prio_reg <= `SPPT_RST_ZERO8;
			analog_cfg_reg <= `SPPT_RST_ZERO8;
		end
		else if (wr_acc)
		begin
			case (i_address)
				`SPPT_OFS_IRQ_ENABLE:
					irq_en_reg <= i_writedata[7:0];
				`SPPT_OFS_IRQ_PRIO:
					irq_prio_reg <= i_writedata[7:0];
				`SPPT_OFS_ANALOG_CFG:
					analog_cfg_reg <= i_writedata[7:0];
				default:
					irq_en_reg <= irq_en_reg;
			endcase
		end
	end

	// Core output latch and captured external word
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			in_word_reg <= {DW{1'b0}};
			data_latch_reg <= {DW{1'b0}};
		end
		else
		begin
			if (core_wr_data)
				data_latch_reg <= i_writedata[DW-1:0];
			if (ext_wr)
				in_word_reg <= data_sync;
		end
	end

	// Input word pending; a new external write wins over a core read
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			in_pend_reg <= 1'b0;
		else if (ext_wr)
			in_pend_reg <= 1'b1;
		else if (core_rd_data && sel_reg)
			in_pend_reg <= 1'b0;
	end

	// Output word pending; a core write wins over an external read
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			out_pend_reg <= 1'b0;
		else if (core_wr_data && sel_reg)
			out_pend_reg <= 1'b1;
		else if (ext_rd)
			out_pend_reg <= 1'b0;
	end

	// Overrun: only a software write of zero clears it; an event wins
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			overrun_reg <= 1'b0;
		else if (ext_wr && in_pend_reg)
			overrun_reg <= 1'b1;
		else if (wr_status && !i_writedata[`SPPT_BIT_OVERRUN])
			overrun_reg <= 1'b0;
	end

	// Interrupt flags: write one to clear; a new event wins
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			irq_flag_reg <= `SPPT_RST_ZERO8;
		else
		begin
			if (wr_flags)
				irq_flag_reg <= irq_flag_reg & ~i_writedata[7:0];
			if (ext_wr | ext_rd_end)
				irq_flag_reg[`SPPT_BIT_SPIRQ] <= 1'b1;
		end
	end

	// Data pins: GPIO latch and direction, or driven during a host read
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_data_pin <= {DW{1'b0}};
			o_data_oe <= {DW{1'b0}};
		end
		else
		begin
			o_data_pin <= data_latch_reg;
			if (sel_reg)
				o_data_oe <= rd_pair ? {DW{1'b1}} : {DW{1'b0}};
			else
				o_data_oe <= ~data_dir_reg;
		end
	end

	// Control pins are never driven in slave port mode
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_ctl_pin <= 3'h0;
			o_ctl_oe <= 3'h0;
		end
		else
		begin
			o_ctl_pin <= ctl_latch_reg;
			o_ctl_oe <= sel_reg ? 3'h0 : ~ctl_dir_reg;
		end
	end

	// Level interrupt from unmasked flags
	always @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_flag_reg & irq_en_reg);
	end
endmodule

// file: sppt_assertions.sv
// Concurrent checks on the slave port register bus and pins
`timescale 1ns/10ps
module sppt_assertions
(
	input wire i_clk,
	input wire i_rst_n,
	input wire [3:0] i_address,
	input wire i_read,
	input wire i_write,
	input wire [31:0] o_readdata,
	input wire o_waitrequest,
	input wire [7:0] o_data_oe,
	input wire o_irq
);
	wire req = i_read | i_write;
	wire ans = !o_waitrequest;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	chk_wait_answer: assert property (req && !ans |=> ans)
		else $error("request not answered in one cycle");
	chk_wait_pulse: assert property (ans |=> !ans)
		else $error("answer longer than one cycle");
	chk_no_spurious: assert property (!req && !ans |=> !ans)
		else $error("answer without a request");
	chk_rdata_upper: assert property (o_readdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	chk_rsvd_bit3: assert property (ans && i_read && i_address == 4'h5
		|-> !o_readdata[3])
		else $error("reserved status bit reads one");
	chk_unmapped_zero: assert property (ans && i_read
		&& i_address > 4'h9 |-> o_readdata == 32'h0)
		else $error("unmapped index reads nonzero");
	chk_rdata_hold: assert property ($changed(o_readdata)
		|-> ans && i_read)
		else $error("read data moved outside a read answer");
	chk_reset_quiet: assert property ($rose(i_rst_n)
		|-> o_waitrequest && !o_irq && o_data_oe == 8'h0)
		else $error("outputs not idle after reset");
	cov_read: cover property (ans && i_read);
	cov_irq: cover property ($rose(o_irq));
	cov_drive: cover property (o_data_oe == 8'hFF);
endmodule

// file: sppt_host.sv
// External processor model on the far side of the slave port
`timescale 1ns/10ps
module sppt_host
(
	input wire i_clk,
	input wire [7:0] i_dev_data,
	input wire [7:0] i_dev_oe,
	output reg [2:0] o_ctl,
	output wire [7:0] o_bus
);
	reg drv = 1'b0;
	reg [7:0] val = 8'h00;
	// Released bus lines show the inverse of the last value
	assign o_bus = (i_dev_oe & i_dev_data)
		| (~i_dev_oe & (drv ? val : ~val));
	initial o_ctl = 3'h7;
	task put(input [7:0] d, input cs);
	begin
		val <= d;
		drv <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_ctl <= {cs, 2'b01};
		repeat (5) @(posedge i_clk);
		o_ctl <= 3'h7;
		@(posedge i_clk);
		drv <= 1'b0;
		repeat (3) @(posedge i_clk);
	end
	endtask
	task get(output [7:0] d);
	begin
		o_ctl <= 3'h2;
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		d = o_bus;
		@(posedge i_clk);
		o_ctl <= 3'h7;
		repeat (4) @(posedge i_clk);
	end
	endtask
endmodule

// file: tb.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/10ps
module tb;
	localparam [31:0] ADR = 32'hF8397625;
	localparam [63:0] EXP = 64'h000000000000FF07;
	reg i_clk = 1'b0;
	reg i_rst_n = 1'b0;
	reg [3:0] i_address = 4'h0;
	reg i_read = 1'b0;
	reg i_write = 1'b0;
	reg [31:0] i_writedata = 32'h0;
	wire [31:0] o_readdata;
	wire o_waitrequest;
	wire [7:0] o_data_pin;
	wire [7:0] o_data_oe;
	wire [7:0] bus;
	wire [2:0] o_ctl_pin;
	wire [2:0] o_ctl_oe;
	wire [2:0] ctl;
	wire o_irq;
	wire [2:0] cw = (o_ctl_oe & o_ctl_pin) | (~o_ctl_oe & ctl);
	integer num_errors = 0;
	integer samples_checked = 0;
	integer k;
	reg [7:0] q;
	always #25 i_clk = ~i_clk;
	sppt_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_data_pin(bus), .o_data_pin(o_data_pin), .o_data_oe(o_data_oe),
		.i_ctl_pin(cw), .o_ctl_pin(o_ctl_pin), .o_ctl_oe(o_ctl_oe),
		.o_irq(o_irq));
	sppt_host h (.i_clk(i_clk), .i_dev_data(o_data_pin),
		.i_dev_oe(o_data_oe), .o_ctl(ctl), .o_bus(bus));
	task end_of_test;
	begin
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task acc(input w, input [3:0] a, input [7:0] d, output [7:0] r);
		integer n;
	begin
		n = 0;
		i_address <= a;
		i_read <= ~w;
		i_write <= w;
		i_writedata <= {24'h0, d};
		@(posedge i_clk);
		while (o_waitrequest !== 1'b0 && n < 20)
		begin
			n = n + 1;
			@(posedge i_clk);
		end
		if (n >= 20)
			num_errors = num_errors + 1;
		r = o_readdata[7:0];
		i_read <= 1'b0;
		i_write <= 1'b0;
		@(posedge i_clk);
	end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		acc(1'b1, a, d, q);
	endtask
	task rd(input [3:0] a, input [7:0] e);
	begin
		acc(1'b0, a, 8'h00, q);
		cmp(q, e);
	end
	endtask
	initial
	begin
		repeat (4000) @(posedge i_clk);
		num_errors = num_errors + 1;
		end_of_test;
	end
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (k = 0; k < 8; k = k + 1)
			rd(ADR[k*4+:4], EXP[k*8+:8]);
		wr(4'h9, 8'h07);
		wr(4'h5, 8'h1F);
		wr(4'h7, 8'h80);
		rd(4'h5, 8'h17);
		h.put(8'hA5, 1'b0);
		rd(4'h5, 8'h97);
		rd(4'h6, 8'h80);
		cmp(o_irq, 1'b1);
		rd(4'h0, 8'hA5);
		h.put(8'h3C, 1'b0);
		h.put(8'hC3, 1'b0);
		rd(4'h5, 8'hB7);
		acc(1'b0, 4'h0, 8'h00, q);
		rd(4'h5, 8'h37);
		wr(4'h5, 8'h17);
		rd(4'h5, 8'h17);
		wr(4'h6, 8'h80);
		rd(4'h6, 8'h00);
		cmp(o_irq, 1'b0);
		wr(4'h0, 8'h5A);
		rd(4'h5, 8'h57);
		h.get(q);
		cmp(q, 8'h5A);
		rd(4'h5, 8'h17);
		rd(4'h6, 8'h80);
		h.put(8'h11, 1'b1);
		rd(4'h5, 8'h17);
		wr(4'h5, 8'h05);
		wr(4'h2, 8'h0F);
		wr(4'h1, 8'h33);
		wr(4'h4, 8'h06);
		@(posedge i_clk);
		cmp(o_ctl_oe, 3'h2);
		cmp(o_data_oe, 8'hF0);
		cmp(o_data_pin, 8'h33);
		cmp(o_ctl_pin, 3'h6);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(4'h5, 8'h07);
		rd(4'h2, 8'hFF);
		rd(4'h6, 8'h00);
		end_of_test;
	end
endmodule
bind sppt_top sppt_assertions chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_address(i_address), .i_read(i_read), .i_write(i_write),
	.o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
	.o_data_oe(o_data_oe), .o_irq(o_irq));
